// ### tao_exec.sv
// execution datapath for transfer, stack and integer arithmetic operations
`timescale 1ns/1ns
`default_nettype none
module tao_exec #(
	parameter int NUM_REGS = 8,
	parameter int DATA_W   = 32
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic              OP_VALID,
	input  wire tao_pkg::tao_op_t   OP_CODE,
	input  wire tao_pkg::tao_size_t OP_SIZE,
	input  wire logic [2:0]        OP_DST,
	input  wire logic              OP_DST_HI,
	input  wire logic [2:0]        OP_SRC,
	input  wire logic              OP_SRC_HI,
	input  wire logic              OP_USE_IMM,
	input  wire logic [31:0]       OP_IMM,
	input  wire tao_pkg::tao_len_t  OP_IMM_LEN,
	input  wire logic [31:0]       OP_DISP,
	input  wire tao_pkg::tao_len_t  OP_DISP_LEN,
	input  wire logic [1:0]        OP_STEP,
	input  wire logic [31:0]       MEM_RDATA,
	input  wire logic              MEM_ACK,
	input  wire logic [2:0]        REG_RD_SEL,
	output logic                   OP_READY,
	output logic                   OP_DONE,
	output logic                   OP_ERROR,
	output logic [3:0]             FLAGS,
	output logic                   MEM_REQ,
	output logic                   MEM_WE,
	output logic [31:0]            MEM_ADDR,
	output logic [31:0]            MEM_WDATA,
	output tao_pkg::tao_size_t      MEM_SIZE,
	output logic [31:0]            REG_RD_DATA
);
	import tao_pkg::*;

	if (NUM_REGS != 8 || DATA_W != 32) begin : g_bad_param
		$error("tao_exec serves only eight 32-bit registers");
	end

	// --------------------------------------------------------------
	// operand access
	// --------------------------------------------------------------
	function automatic logic [31:0] get_opnd(input logic [31:0] r, input tao_size_t s,
		input logic hi);
		case (s)
			SZ_BYTE: get_opnd = hi ? {24'h0, r[15:8]} : {24'h0, r[7:0]};
			SZ_WORD: get_opnd = hi ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
			default: get_opnd = r;
		endcase
	endfunction : get_opnd

	function automatic logic [31:0] put_opnd(input logic [31:0] r, input logic [31:0] v,
		input tao_size_t s, input logic hi);
		case (s)
			SZ_BYTE: put_opnd = hi ? {r[31:16], v[7:0], r[7:0]} : {r[31:8], v[7:0]};
			SZ_WORD: put_opnd = hi ? {v[15:0], r[15:0]} : {r[31:16], v[15:0]};
			default: put_opnd = v;
		endcase
	endfunction : put_opnd

	function automatic logic [31:0] ext_field(input logic [31:0] f, input tao_len_t l,
		input logic sgn);
		case (l)
			LEN_3:   ext_field = {29'h0, f[2:0]};
			LEN_8:   ext_field = {{24{sgn & f[7]}}, f[7:0]};
			LEN_16:  ext_field = {{16{sgn & f[15]}}, f[15:0]};
			LEN_24:  ext_field = {{8{sgn & f[23]}}, f[23:0]};
			default: ext_field = f;
		endcase
	endfunction : ext_field

	function automatic logic [31:0] size_bytes(input tao_size_t s);
		size_bytes = (s == SZ_LONG) ? BYTES_LONG : BYTES_WORD;
	endfunction : size_bytes

	logic [31:0] gr_reg [8];
	logic [3:0]  flags_reg;
	logic        half_reg;
	tao_state_t  state_reg;
	logic        pull_reg;
	logic [2:0]  ld_dst_reg;
	logic        ld_hi_reg;

	logic        accept;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] stepv;
	logic [32:0] res;
	logic [31:0] prod;
	logic [31:0] ea;
	logic        sub;
	logic        bad;
	logic        wr_en;
	logic        mem_go;
	logic        set_nz;
	logic        set_vc;
	logic        keep_z;
	logic        clr_v;
	logic [2:0]  wr_idx;
	logic        wr_hi;
	tao_size_t   wr_size;
	tao_size_t   fsz;
	logic        rm;
	logic        am;
	logic        bm;
	logic        co;
	logic        hc;
	logic        zr;
	logic [3:0]  flags_next;
	logic        half_next;

	assign accept = OP_VALID & OP_READY;

	// --------------------------------------------------------------
	// operation decode and arithmetic
	// --------------------------------------------------------------
	always_comb begin
		a = get_opnd(gr_reg[OP_DST], OP_SIZE, OP_DST_HI);
		b = OP_USE_IMM ? ext_field(OP_IMM, OP_IMM_LEN, 1'b0)
			: get_opnd(gr_reg[OP_SRC], OP_SIZE, OP_SRC_HI);
		stepv = (OP_STEP == 2'h0) ? 32'h1 : (OP_STEP == 2'h1) ? 32'h2 : 32'h4;
		ea = (OP_USE_IMM ? ext_field(OP_IMM, OP_IMM_LEN, 1'b0)
			: gr_reg[(OP_CODE == OP_LOAD) ? OP_SRC : OP_DST])
			+ ext_field(OP_DISP, OP_DISP_LEN, 1'b1);
		prod = 32'h0;
		res = 33'h0;
		sub = 1'b0;
		bad = 1'b0;
		wr_en = 1'b0;
		mem_go = 1'b0;
		set_nz = 1'b0;
		set_vc = 1'b0;
		keep_z = 1'b0;
		clr_v = 1'b0;
		wr_idx = OP_DST;
		wr_hi = OP_DST_HI;
		wr_size = OP_SIZE;
		fsz = OP_SIZE;
		case (OP_CODE)
			OP_TRANSFER: begin
				res = {1'b0, b};
				wr_en = 1'b1;
				set_nz = 1'b1;
				clr_v = 1'b1;
			end
			OP_LOAD, OP_STORE: begin
				mem_go = 1'b1;
			end
			OP_PULL, OP_PUSH: begin
				bad = (OP_SIZE == SZ_BYTE);
				mem_go = ~bad;
				wr_en = (OP_CODE == OP_PUSH) & ~bad;
				wr_idx = SP_INDEX;
				wr_hi = 1'b0;
				wr_size = SZ_LONG;
				res = {1'b0, gr_reg[SP_INDEX] - size_bytes(OP_SIZE)};
			end
			OP_SUM, OP_DIFF, OP_CARRY_SUM, OP_BORROW_DIFF: begin
				sub = (OP_CODE == OP_DIFF) | (OP_CODE == OP_BORROW_DIFF);
				bad = (OP_CODE == OP_DIFF && OP_USE_IMM && OP_SIZE == SZ_BYTE)
					| (OP_CODE inside {OP_CARRY_SUM, OP_BORROW_DIFF} && OP_SIZE != SZ_BYTE);
				keep_z = OP_CODE inside {OP_CARRY_SUM, OP_BORROW_DIFF};
				res = sub ? {1'b0, a} - {1'b0, b} - {32'h0, keep_z & flags_reg[FLAG_C]}
					: {1'b0, a} + {1'b0, b} + {32'h0, keep_z & flags_reg[FLAG_C]};
				wr_en = ~bad;
				set_nz = 1'b1;
				set_vc = 1'b1;
			end
			OP_STEP_UP, OP_STEP_DOWN: begin
				sub = (OP_CODE == OP_STEP_DOWN);
				bad = (OP_STEP > 2'h1) | (OP_SIZE == SZ_BYTE && OP_STEP != 2'h0);
				res = sub ? {1'b0, a} - {1'b0, stepv} : {1'b0, a} + {1'b0, stepv};
				wr_en = ~bad;
				set_nz = 1'b1;
			end
			OP_WIDE_PLUS, OP_WIDE_MINUS: begin
				bad = (OP_SIZE != SZ_LONG) | (OP_STEP == 2'h3);
				res = (OP_CODE == OP_WIDE_MINUS) ? {1'b0, gr_reg[OP_DST] - stepv}
					: {1'b0, gr_reg[OP_DST] + stepv};
				wr_en = ~bad;
			end
			OP_BCD_SUM: begin
				bad = (OP_SIZE != SZ_BYTE);
				res = {1'b0, a}
					+ {25'h0, (half_reg || a[3:0] > BCD_DIGIT) ? BCD_FIX_LO : 8'h0}
					+ {25'h0, (flags_reg[FLAG_C] || a[7:0] > BCD_MAX) ? BCD_FIX_HI : 8'h0};
				wr_en = ~bad;
				set_nz = 1'b1;
			end
			OP_BCD_DIFF: begin
				bad = (OP_SIZE != SZ_BYTE);
				res = {1'b0, a} - {25'h0, half_reg ? BCD_FIX_LO : 8'h0}
					- {25'h0, flags_reg[FLAG_C] ? BCD_FIX_HI : 8'h0};
				wr_en = ~bad;
				set_nz = 1'b1;
			end
			OP_MUL_U, OP_MUL_S: begin
				bad = (OP_SIZE == SZ_LONG) | OP_USE_IMM;
				if (OP_SIZE == SZ_BYTE) begin
					prod = (OP_CODE == OP_MUL_S)
						? {16'h0, 16'($signed(gr_reg[OP_DST][7:0]) * $signed(b[7:0]))}
						: {16'h0, 16'(gr_reg[OP_DST][7:0] * b[7:0])};
					wr_size = SZ_WORD;
					fsz = SZ_WORD;
				end else begin
					prod = (OP_CODE == OP_MUL_S)
						? 32'($signed(gr_reg[OP_DST][15:0]) * $signed(b[15:0]))
						: 32'(gr_reg[OP_DST][15:0] * b[15:0]);
					wr_size = SZ_LONG;
					fsz = SZ_LONG;
				end
				res = {1'b0, prod};
				wr_hi = 1'b0;
				wr_en = ~bad;
				set_nz = (OP_CODE == OP_MUL_S);
			end
			default: bad = 1'b1;
		endcase
	end

	// --------------------------------------------------------------
	// flag evaluation
	// --------------------------------------------------------------
	always_comb begin
		case (fsz)
			SZ_BYTE: begin
				rm = res[7];
				am = a[7];
				bm = b[7];
				co = res[8];
				hc = a[4] ^ b[4] ^ res[4];
				zr = (res[7:0] == 8'h0);
			end
			SZ_WORD: begin
				rm = res[15];
				am = a[15];
				bm = b[15];
				co = res[16];
				hc = a[12] ^ b[12] ^ res[12];
				zr = (res[15:0] == 16'h0);
			end
			default: begin
				rm = res[31];
				am = a[31];
				bm = b[31];
				co = res[32];
				hc = a[28] ^ b[28] ^ res[28];
				zr = (res[31:0] == 32'h0);
			end
		endcase
		flags_next = flags_reg;
		half_next = half_reg;
		if (set_nz) begin
			flags_next[FLAG_N] = rm;
			flags_next[FLAG_Z] = keep_z ? (zr & flags_reg[FLAG_Z]) : zr;
		end
		if (clr_v)
			flags_next[FLAG_V] = 1'b0;
		if (OP_CODE inside {OP_STEP_UP, OP_STEP_DOWN})
			flags_next[FLAG_V] = (am != rm) & (sub ? am : ~am) & (res[31:0] != 32'h0);
		if (OP_CODE == OP_BCD_SUM)
			flags_next[FLAG_C] = flags_reg[FLAG_C] | (a[7:0] > BCD_MAX);
		if (set_vc) begin
			flags_next[FLAG_V] = (sub ? (am != bm) : (am == bm)) & (rm != am);
			flags_next[FLAG_C] = co;
			half_next = hc;
		end
	end

	// --------------------------------------------------------------
	// sequencing and memory access
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			OP_READY <= 1'b0;
			OP_DONE <= 1'b0;
			OP_ERROR <= 1'b0;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 32'h0;
			MEM_WDATA <= 32'h0;
			MEM_SIZE <= SZ_BYTE;
			pull_reg <= 1'b0;
			ld_dst_reg <= 3'h0;
			ld_hi_reg <= 1'b0;
		end else begin
			OP_DONE <= 1'b0;
			OP_ERROR <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					OP_READY <= 1'b1;
					if (accept && (bad || !mem_go)) begin
						OP_DONE <= 1'b1;
						OP_ERROR <= bad;
					end else if (accept) begin
						state_reg <= ST_MEM;
						OP_READY <= 1'b0;
						MEM_REQ <= 1'b1;
						MEM_WE <= OP_CODE inside {OP_STORE, OP_PUSH};
						MEM_SIZE <= OP_SIZE;
						pull_reg <= (OP_CODE == OP_PULL);
						ld_dst_reg <= OP_DST;
						ld_hi_reg <= OP_DST_HI;
						// stack forms take the pointer, pre-decremented for a push
						MEM_ADDR <= (OP_CODE == OP_PUSH) ? res[31:0]
							: (OP_CODE == OP_PULL) ? gr_reg[SP_INDEX] : ea;
						MEM_WDATA <= get_opnd(gr_reg[(OP_CODE == OP_PUSH) ? OP_DST : OP_SRC],
							OP_SIZE, (OP_CODE == OP_PUSH) ? 1'b0 : OP_SRC_HI);
					end
				end
				ST_MEM: begin
					if (MEM_ACK) begin
						state_reg <= ST_IDLE;
						MEM_REQ <= 1'b0;
						MEM_WE <= 1'b0;
						OP_DONE <= 1'b1;
						OP_READY <= 1'b1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// general registers
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 8; i++) begin
				gr_reg[i] <= REG_RESET;
			end
		end else if (state_reg == ST_IDLE && accept && wr_en) begin
			gr_reg[wr_idx] <= put_opnd(gr_reg[wr_idx], res[31:0], wr_size, wr_hi);
		end else if (state_reg == ST_MEM && MEM_ACK && !MEM_WE) begin
			if (pull_reg)
				gr_reg[SP_INDEX] <= gr_reg[SP_INDEX] + size_bytes(MEM_SIZE);
			// a pull into the pointer itself keeps the loaded value
			gr_reg[ld_dst_reg] <= put_opnd(gr_reg[ld_dst_reg], MEM_RDATA, MEM_SIZE,
				ld_hi_reg & ~pull_reg);
		end
	end

	// --------------------------------------------------------------
	// flags and register observation
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			flags_reg <= FLAGS_RESET;
			half_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && accept && !bad) begin
			flags_reg <= flags_next;
			half_reg <= half_next;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			FLAGS <= FLAGS_RESET;
			REG_RD_DATA <= REG_RESET;
		end else begin
			FLAGS <= flags_next;
			if (!(state_reg == ST_IDLE && accept && !bad))
				FLAGS <= flags_reg;
			REG_RD_DATA <= gr_reg[REG_RD_SEL];
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	chk_psync_refused: assert property (
		accept && OP_CODE inside {OP_PSYNC_LOAD, OP_PSYNC_STORE} |=> OP_ERROR && !MEM_REQ)
		else $error("peripheral sync transfer not refused");
	chk_sub_imm_byte: assert property (
		accept && OP_CODE == OP_DIFF && OP_USE_IMM && OP_SIZE == SZ_BYTE
		|=> OP_ERROR && $stable(flags_reg))
		else $error("byte immediate difference accepted");
	chk_push_sp_dec: assert property (
		accept && OP_CODE == OP_PUSH && OP_SIZE == SZ_WORD
		|=> gr_reg[SP_INDEX] == $past(gr_reg[SP_INDEX]) - 32'h2 && MEM_WE
		&& MEM_ADDR == gr_reg[SP_INDEX])
		else $error("word push did not pre-decrement stack pointer by two");
	chk_pull_sp_inc: assert property (
		state_reg == ST_MEM && pull_reg && MEM_ACK && MEM_SIZE == SZ_LONG
		&& ld_dst_reg != SP_INDEX |=> gr_reg[SP_INDEX] == $past(MEM_ADDR) + 32'h4)
		else $error("long pull did not post-increment stack pointer by four");
	chk_byte_step_two: assert property (
		accept && OP_CODE inside {OP_STEP_UP, OP_STEP_DOWN} && OP_SIZE == SZ_BYTE
		&& OP_STEP != 2'h0 |=> OP_ERROR)
		else $error("byte step by two accepted");
	chk_wide_step_flags: assert property (
		accept && OP_CODE inside {OP_WIDE_PLUS, OP_WIDE_MINUS} |=> $stable(flags_reg))
		else $error("wide step changed flags");
	chk_mulu_byte: assert property (
		accept && OP_CODE == OP_MUL_U && OP_SIZE == SZ_BYTE && !OP_USE_IMM && !OP_SRC_HI
		|=> gr_reg[$past(OP_DST)][15:0]
		== 16'($past(gr_reg[OP_DST][7:0]) * $past(gr_reg[OP_SRC][7:0])))
		else $error("byte unsigned product wrong");
	chk_carry_sum_val: assert property (
		accept && OP_CODE == OP_CARRY_SUM && OP_SIZE == SZ_BYTE && !OP_USE_IMM
		&& !OP_DST_HI && !OP_SRC_HI |=> gr_reg[$past(OP_DST)][7:0]
		== 8'($past(gr_reg[OP_DST][7:0]) + $past(gr_reg[OP_SRC][7:0])
		+ {7'h0, $past(flags_reg[FLAG_C])}))
		else $error("carry sum ignored carry flag");
	chk_mem_hold: assert property (
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && !OP_READY)
		else $error("memory request dropped before acknowledge");

endmodule : tao_exec
`default_nettype wire

// ### tao_exec_test.sv
// self-checking testbench of the transfer and arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module tao_exec_test;
	import tao_pkg::*;

	typedef struct {
		tao_op_t op; tao_size_t sz; logic [2:0] d; logic dh; logic [2:0] s; logic sh;
		logic ui; logic [31:0] iv; tao_len_t il; logic [7:0] dv; logic [1:0] st;
		logic [2:0] ck; logic [31:0] ex; logic er; logic [3:0] fm; logic [3:0] fv;
	} tao_row_t;

	logic clk, rst_n, op_valid, op_dst_hi, op_src_hi, op_use_imm, mem_ack, op_ready;
	logic op_done, op_error, mem_req, mem_we;
	tao_op_t op_code;
	tao_size_t op_size, mem_size;
	tao_len_t imm_len, disp_len;
	logic [2:0] op_dst, op_src, reg_sel, lat;
	logic [1:0] op_step;
	logic [3:0] flags;
	logic [31:0] op_imm, op_disp, mem_rdata, mem_addr, mem_wdata, reg_data;
	int bad_count = 0;
	int tests_run = 0;

	localparam int NR = 40;
	// ---------------------------------------------------------------
	// ordinary cases: operation, then register and flags it leaves
	// ---------------------------------------------------------------
	tao_row_t rows [NR] = '{
'{OP_TRANSFER,SZ_LONG,1,0,0,0,1,32'h12345678,LEN_32,0,0,1,32'h12345678,0,15,0},
'{OP_TRANSFER,SZ_LONG,2,0,0,0,1,32'hFFFFFF80,LEN_8,0,0,2,32'h80,0,15,0},
'{OP_TRANSFER,SZ_BYTE,2,1,1,0,0,0,LEN_8,0,0,2,32'h7880,0,15,0},
'{OP_TRANSFER,SZ_WORD,3,1,1,1,0,0,LEN_8,0,0,3,32'h12340000,0,15,0},
'{OP_SUM,SZ_BYTE,2,0,0,0,1,32'h90,LEN_8,0,0,2,32'h7810,0,15,3},
'{OP_CARRY_SUM,SZ_BYTE,2,0,0,0,1,32'h5,LEN_8,0,0,2,32'h7816,0,15,0},
'{OP_BORROW_DIFF,SZ_BYTE,2,0,2,1,0,0,LEN_8,0,0,2,32'h789E,0,15,9},
'{OP_DIFF,SZ_WORD,3,1,1,0,0,0,LEN_8,0,0,3,32'hBBBC0000,0,15,9},
'{OP_DIFF,SZ_BYTE,3,0,0,0,1,32'h1,LEN_8,0,0,3,32'hBBBC0000,1,15,9},
'{OP_STEP_UP,SZ_BYTE,2,0,0,0,0,0,LEN_8,0,1,2,32'h789E,1,15,9},
'{OP_STEP_DOWN,SZ_WORD,4,0,0,0,0,0,LEN_8,0,1,4,32'hFFFE,0,15,9},
'{OP_STEP_UP,SZ_LONG,4,0,0,0,0,0,LEN_8,0,3,4,32'hFFFE,1,15,9},
'{OP_WIDE_PLUS,SZ_LONG,1,0,0,0,0,0,LEN_8,0,2,1,32'h1234567C,0,15,9},
'{OP_WIDE_MINUS,SZ_WORD,1,0,0,0,0,0,LEN_8,0,1,1,32'h1234567C,1,15,9},
'{OP_WIDE_MINUS,SZ_LONG,1,0,0,0,0,0,LEN_8,0,1,1,32'h1234567A,0,15,9},
'{OP_MUL_U,SZ_BYTE,2,0,1,0,0,0,LEN_8,0,0,2,32'h4B4C,0,15,9},
'{OP_MUL_S,SZ_WORD,4,0,1,0,0,0,LEN_8,0,0,4,32'hFFFF530C,0,15,9},
'{OP_MUL_U,SZ_LONG,2,0,1,0,0,0,LEN_8,0,0,2,32'h4B4C,1,15,9},
'{OP_PSYNC_LOAD,SZ_BYTE,2,0,0,0,1,32'h200,LEN_16,0,0,2,32'h4B4C,1,15,9},
'{OP_PSYNC_STORE,SZ_BYTE,0,0,2,0,1,32'h200,LEN_16,0,0,2,32'h4B4C,1,15,9},
'{OP_TRANSFER,SZ_BYTE,6,0,0,0,1,32'h38,LEN_8,0,0,6,32'h38,0,15,1},
'{OP_SUM,SZ_BYTE,6,0,0,0,1,32'h45,LEN_8,0,0,6,32'h7D,0,15,0},
'{OP_BCD_SUM,SZ_BYTE,6,0,0,0,0,0,LEN_8,0,0,6,32'h83,0,1,0},
'{OP_TRANSFER,SZ_BYTE,5,0,0,0,1,32'h29,LEN_8,0,0,5,32'h29,0,15,0},
'{OP_DIFF,SZ_BYTE,6,0,5,0,0,0,LEN_8,0,0,6,32'h5A,0,15,2},
'{OP_BCD_DIFF,SZ_BYTE,6,0,0,0,0,0,LEN_8,0,0,6,32'h54,0,3,2},
'{OP_BCD_SUM,SZ_WORD,6,0,0,0,0,0,LEN_8,0,0,6,32'h54,1,3,2},
'{OP_TRANSFER,SZ_LONG,7,0,0,0,1,32'h100,LEN_16,0,0,7,32'h100,0,15,0},
'{OP_PUSH,SZ_WORD,1,0,1,0,0,0,LEN_8,0,0,7,32'hFE,0,0,0},
'{OP_PUSH,SZ_LONG,3,0,3,0,0,0,LEN_8,0,0,7,32'hFA,0,0,0},
'{OP_PULL,SZ_LONG,5,0,5,0,0,0,LEN_8,0,0,5,32'hBBBC0000,0,0,0},
'{OP_PULL,SZ_WORD,6,0,6,0,0,0,LEN_8,0,0,7,32'h100,0,0,0},
'{OP_PUSH,SZ_BYTE,6,0,6,0,0,0,LEN_8,0,0,6,32'h567A,1,0,0},
'{OP_STORE,SZ_LONG,0,0,1,0,1,32'h200,LEN_16,8'hFC,0,7,32'h100,0,0,0},
'{OP_LOAD,SZ_LONG,0,0,0,0,1,32'h1F0,LEN_16,8'h0C,0,0,32'h1234567A,0,0,0},
'{OP_LOAD,SZ_WORD,4,0,7,0,0,0,LEN_8,8'hFE,0,4,32'hFFFF567A,0,0,0},
'{OP_TRANSFER,SZ_LONG,5,0,0,0,1,32'hFFABCDEF,LEN_24,0,0,5,32'hABCDEF,0,15,0},
'{OP_SUM,SZ_BYTE,2,0,0,0,1,32'hC0,LEN_8,0,0,2,32'h4B0C,0,15,1},
'{OP_CARRY_SUM,SZ_BYTE,2,0,6,0,0,0,LEN_8,0,0,2,32'h4B87,0,15,10},
'{OP_SUM,SZ_BYTE,2,0,0,0,1,32'hFF,LEN_3,0,0,2,32'h4B8E,0,15,8}};

	tao_exec tao_exec_inst (.CORE_CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
		.OP_CODE(op_code), .OP_SIZE(op_size), .OP_DST(op_dst), .OP_DST_HI(op_dst_hi),
		.OP_SRC(op_src), .OP_SRC_HI(op_src_hi), .OP_USE_IMM(op_use_imm), .OP_IMM(op_imm),
		.OP_IMM_LEN(imm_len), .OP_DISP(op_disp), .OP_DISP_LEN(disp_len), .OP_STEP(op_step),
		.MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .REG_RD_SEL(reg_sel),
		.OP_READY(op_ready), .OP_DONE(op_done), .OP_ERROR(op_error), .FLAGS(flags),
		.MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
		.MEM_SIZE(mem_size), .REG_RD_DATA(reg_data));

	tao_mem_model tao_mem_model_inst (.CORE_CLK(clk), .RST_N(rst_n), .MEM_REQ(mem_req),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_SIZE(mem_size),
		.LAT(lat), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	task automatic put(input tao_row_t r);
		op_code    <= r.op;
		op_size    <= r.sz;
		op_dst     <= r.d;
		op_dst_hi  <= r.dh;
		op_src     <= r.s;
		op_src_hi  <= r.sh;
		op_use_imm <= r.ui;
		op_imm     <= r.iv;
		imm_len    <= r.il;
		op_disp    <= {24'h0, r.dv};
		op_step    <= r.st;
	endtask : put

	task automatic rd(input logic [2:0] s, input logic [31:0] e);
		@(posedge clk);
		reg_sel <= s;
		@(posedge clk);
		@(negedge clk);
		cmp("register", e, reg_data);
	endtask : rd

	// request held until the edge that sees ready, then released at that edge
	task automatic run(input tao_row_t r);
		int i;
		@(posedge clk);
		put(r);
		op_valid <= 1'b1;
		@(negedge clk);
		for (i = 0; i < 50 && op_ready !== 1'b1; i++) @(negedge clk);
		if (i == 50) begin
			bad_count++;
			results();
		end
		@(posedge clk);
		op_valid <= 1'b0;
		for (i = 0; i < 50; i++) begin
			@(negedge clk);
			if (op_done === 1'b1) break;
		end
		if (i == 50) begin
			bad_count++;
			results();
		end
		cmp("refusal", {31'h0, r.er}, {31'h0, op_error});
		cmp("flags", {28'h0, r.fv & r.fm}, {28'h0, flags & r.fm});
		rd(r.ck, r.ex);
	endtask : run

	initial begin
		rst_n = 1'b0; op_valid = 1'b0; reg_sel = 3'h0; lat = 3'h0; disp_len = LEN_8;
		put(rows[0]);
		repeat (20) @(posedge clk);
		cmp("ready in reset", 32'h0, {31'h0, op_ready});
		rst_n <= 1'b1;
		for (int k = 0; k < NR; k++) begin
			lat = k[0] ? 3'h3 : 3'h0;
			run(rows[k]);
		end
		// ---------------------------------------------------------------
		// back to back register ops, one taken per edge
		// ---------------------------------------------------------------
		@(posedge clk);
		put('{OP_STEP_UP,SZ_LONG,0,0,0,0,0,0,LEN_8,0,0,0,0,0,0,0});
		op_valid <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		cmp("first done", 32'h1, {31'h0, op_done});
		@(posedge clk);
		op_valid <= 1'b0;
		rd(3'h0, 32'h1234567C);
		// ---------------------------------------------------------------
		// reset in mid-run clears registers and flags
		// ---------------------------------------------------------------
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		cmp("flags in reset", 32'h0, {28'h0, flags});
		@(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		cmp("ready after release", 32'h0, {31'h0, op_ready});
		@(negedge clk);
		cmp("ready later", 32'h1, {31'h0, op_ready});
		rd(3'h1, 32'h0);
		results();
	end
endmodule : tao_exec_test
`default_nettype wire

// ### tao_mem_model.sv
// memory side model answering the datapath's memory access port
`timescale 1ns/1ns
`default_nettype none
module tao_mem_model (
	input  wire logic               CORE_CLK,
	input  wire logic               RST_N,
	input  wire logic               MEM_REQ,
	input  wire logic               MEM_WE,
	input  wire logic [31:0]        MEM_ADDR,
	input  wire logic [31:0]        MEM_WDATA,
	input  wire tao_pkg::tao_size_t MEM_SIZE,
	input  wire logic [2:0]         LAT,
	output logic [31:0]             MEM_RDATA,
	output logic                    MEM_ACK
);
	import tao_pkg::*;

	logic [31:0] mem [logic [31:0]];
	logic [2:0]  wait_reg;
	logic [31:0] mask;

	always_comb begin
		mask = (MEM_SIZE == SZ_BYTE) ? 32'h0000_00FF :
			(MEM_SIZE == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	end

	// read data outside an answer toggles every cycle, and unused upper bits carry junk
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MEM_ACK   <= 1'b0;
			wait_reg  <= 3'h0;
			MEM_RDATA <= 32'h5A5A_A5A5;
		end else begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_REQ && !MEM_ACK) begin
				if (wait_reg < LAT) begin
					wait_reg <= wait_reg + 3'h1;
				end else begin
					MEM_ACK  <= 1'b1;
					wait_reg <= 3'h0;
					if (MEM_WE) begin
						mem[MEM_ADDR] = MEM_WDATA & mask;
					end else begin
						MEM_RDATA <= ((mem.exists(MEM_ADDR) ? mem[MEM_ADDR] : 32'h0) & mask)
							| (~mask & ~MEM_RDATA);
					end
				end
			end
		end
	end
endmodule : tao_mem_model
`default_nettype wire

// ### tao_pkg.sv
// shared types and constants of the transfer and arithmetic execution datapath
// What this block does
// - eight 32-bit registers, reachable as whole, halves, and low-half bytes
// - immediate, displacement and absolute fields come in 3, 8, 16, 24 or 32 bits
// - flags hold negative, zero, overflow, carry; arithmetic sets, carry ops read
// - transfer copies reg to reg, reg to and from memory, or immediate to reg
// - peripheral-synchronised byte load and store are refused
// - stack pull equals word or long load from stack pointer with post-increment
// - stack store equals word or long store at stack pointer with pre-decrement
// - sum and difference in byte, word, long; register or immediate second operand
// - difference has no byte immediate form
// - carry sum and borrow difference are byte only and use the carry flag
// - step up and down by 1 or 2; byte operands by 1 only
// - wide steps add or subtract 1, 2 or 4, longword only
// - decimal adjust corrects a byte sum or difference into packed BCD via flags
// - unsigned multiply 8x8 to 16 or 16x16 to 32 into destination
// - signed multiply 8x8 to 16 or 16x16 to 32, two's complement
package tao_pkg;

	typedef enum logic [4:0] {
		OP_TRANSFER    = 5'h00,
		OP_LOAD        = 5'h01,
		OP_STORE       = 5'h02,
		OP_PULL        = 5'h03,
		OP_PUSH        = 5'h04,
		OP_SUM         = 5'h05,
		OP_DIFF        = 5'h06,
		OP_CARRY_SUM   = 5'h07,
		OP_BORROW_DIFF = 5'h08,
		OP_STEP_UP     = 5'h09,
		OP_STEP_DOWN   = 5'h0A,
		OP_WIDE_PLUS   = 5'h0B,
		OP_WIDE_MINUS  = 5'h0C,
		OP_BCD_SUM     = 5'h0D,
		OP_BCD_DIFF    = 5'h0E,
		OP_MUL_U       = 5'h0F,
		OP_MUL_S       = 5'h10,
		OP_PSYNC_LOAD  = 5'h11,
		OP_PSYNC_STORE = 5'h12
	} tao_op_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} tao_size_t;

	typedef enum logic [2:0] {
		LEN_3  = 3'h0,
		LEN_8  = 3'h1,
		LEN_16 = 3'h2,
		LEN_24 = 3'h3,
		LEN_32 = 3'h4
	} tao_len_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MEM  = 2'h1
	} tao_state_t;

	localparam logic [2:0]  SP_INDEX    = 3'h7;
	localparam int          FLAG_N      = 3;
	localparam int          FLAG_Z      = 2;
	localparam int          FLAG_V      = 1;
	localparam int          FLAG_C      = 0;
	localparam logic [3:0]  FLAGS_RESET = 4'h0;
	localparam logic [31:0] REG_RESET   = 32'h0;
	localparam logic [31:0] BYTES_WORD  = 32'h2;
	localparam logic [31:0] BYTES_LONG  = 32'h4;
	localparam logic [7:0]  BCD_MAX     = 8'h99;
	localparam logic [3:0]  BCD_DIGIT   = 4'h9;
	localparam logic [7:0]  BCD_FIX_LO  = 8'h06;
	localparam logic [7:0]  BCD_FIX_HI  = 8'h60;

endpackage : tao_pkg
